// file: sfr_pkg.sv
// shared constants for the serial flash read and page program command logic,
// plus the three-stage pin synchroniser used on every link input.
// assumes one 25 MHz system clock and a host-driven serial clock well below it.
package sfr_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int BUSY_W        = 24;
  localparam int PAGE_BYTES    = 256;
  // ----------------------------------------
  // opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_FAST_RD    = 8'h0B;
  localparam logic [7:0] OP_FAST_RD4   = 8'h0C;
  localparam logic [7:0] OP_DUAL_OUT   = 8'h3B;
  localparam logic [7:0] OP_DUAL_OUT4  = 8'h3C;
  localparam logic [7:0] OP_QUAD_OUT   = 8'h6B;
  localparam logic [7:0] OP_QUAD_OUT4  = 8'h6C;
  localparam logic [7:0] OP_DUAL_IO    = 8'hBB;
  localparam logic [7:0] OP_DUAL_IO4   = 8'hBC;
  localparam logic [7:0] OP_QUAD_IO    = 8'hEB;
  localparam logic [7:0] OP_QUAD_IO4   = 8'hEC;
  localparam logic [7:0] OP_PAGE_PROG  = 8'h02;
  // ----------------------------------------
  // dummy clocks, counts and reset values
  // ----------------------------------------
  localparam logic [5:0] DUMMY_FAST    = 6'h08;
  localparam logic [5:0] DUMMY_DUAL_IO = 6'h04;
  localparam logic [5:0] DUMMY_QUAD_IO = 6'h06;
  localparam logic [5:0] BIT_LAST      = 6'h07;
  localparam logic [3:0] LINES_1       = 4'h1;
  localparam logic [3:0] LINES_2       = 4'h2;
  localparam logic [3:0] LINES_4       = 4'h4;
  localparam logic [3:0] OE_SINGLE     = 4'h2;
  localparam logic [3:0] OE_DUAL       = 4'h3;
  localparam logic [3:0] OE_QUAD       = 4'hF;
  localparam logic [5:0] SYNC_RST      = 6'h01;
  // ----------------------------------------
  // command states
  // ----------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_OPC   = 7'h02,
    ST_ADDR  = 7'h04,
    ST_DUMMY = 7'h08,
    ST_RDATA = 7'h10,
    ST_PDATA = 7'h20,
    ST_SKIP  = 7'h40
  } sfr_state_t;
endpackage

`timescale 1ns/10ps
// three-flop synchroniser with agreement filter and edge pulses.
// assumes inputs are asynchronous pins; bit 0 is chip select, bit 1 serial clock.
module sfr_pin_sync (
  // clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_b_in,
  // raw pins
  input  wire logic [5:0] pins_in,
  // filtered levels and edges
  output logic      [5:0] level_out,
  output logic      [5:0] rise_out,
  output logic      [5:0] fall_out
);
  logic [5:0] s1_ff;
  logic [5:0] s2_ff;
  logic [5:0] s3_ff;
  genvar i;
  generate
    for (i = 0; i < 6; i++) begin : g_bit
      // a change counts only once the second and third stages agree
      wire agree_new = (s2_ff[i] == s3_ff[i]) && (s3_ff[i] != level_out[i]);
      always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
          s1_ff[i]     <= sfr_pkg::SYNC_RST[i];
          s2_ff[i]     <= sfr_pkg::SYNC_RST[i];
          s3_ff[i]     <= sfr_pkg::SYNC_RST[i];
          level_out[i] <= sfr_pkg::SYNC_RST[i];
          rise_out[i]  <= 1'b0;
          fall_out[i]  <= 1'b0;
        end else begin
          s1_ff[i]    <= pins_in[i];
          s2_ff[i]    <= s1_ff[i];
          s3_ff[i]    <= s2_ff[i];
          rise_out[i] <= agree_new && s3_ff[i];
          fall_out[i] <= agree_new && !s3_ff[i];
          if (agree_new) begin
            level_out[i] <= s3_ff[i];
          end
        end
      end
    end
  endgenerate
endmodule

// file: sfr_read_prog_top.sv
// command interpreter for fast reads and page program inside one flash die.
// assumes an array read port answering within one clock and an external
// protection decoder that judges the page on mem_addr_out.
`timescale 1ns/10ps
// Functional notes
// - fast read waits eight dummy clocks after address; lines undriven meanwhile
// - opcodes 0C, 3C, 6C always take a 32-bit address
// - dual output read: single-line address, eight dummies, data on lines 0 and 1
// - quad output read: single-line address, eight dummies, data on lines 0 to 3
// - dual io read: address two bits per clock, four dummies, dual data
// - quad io read: address on four lines, six dummies, quad data
// - opcodes BC and EC always take a 32-bit address
// - page program refused unless write enable latch is set
// - program column wraps inside the 256-byte page, overwriting earlier bytes
// - bytes of the page not sent stay unchanged
// - select must rise on a byte boundary, else the program is dropped
// - valid select rise starts timed busy cycle; busy visible throughout
// - write enable latch cleared when program cycle ends
// - program skipped when the addressed page is protected or locked
// - each die programs on its own; host polls each busy flag
// - opcode and address sampled on serial clock rising edges
// - read data msb first, address increments per byte until select rises
// - reads during a busy cycle are ignored and leave it alone
// - in 3-byte mode bits 31 to 24 come from the extended address input
module sfr_read_prog_top #(
  parameter int PROG_TIME_NS = 400000
) (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_b_in,
  // serial link pins
  input  wire logic        chip_select_b_in,
  input  wire logic        serial_clock_in,
  input  wire logic [3:0]  bidir_line_in,
  output logic      [3:0]  bidir_line_out,
  output logic      [3:0]  bidir_line_oe_out,
  // configuration and status
  input  wire logic        address_size_select_in,
  input  wire logic [7:0]  ext_addr_in,
  input  wire logic        write_enable_set_in,
  input  wire logic        page_locked_in,
  output logic             write_enable_latch_out,
  output logic             busy_out,
  // array ports
  output logic      [31:0] mem_addr_out,
  input  wire logic [7:0]  mem_rdata_in,
  output logic             prog_we_out,
  output logic      [31:0] prog_addr_out,
  output logic      [7:0]  prog_data_out
);
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int PROG_CYC_I = (PROG_TIME_NS + sfr_pkg::CLK_PERIOD_NS - 1)
                              / sfr_pkg::CLK_PERIOD_NS;
  localparam logic [sfr_pkg::BUSY_W-1:0] PROG_LAST = sfr_pkg::BUSY_W'(PROG_CYC_I - 1);
  // ----------------------------------------
  // link synchronisation
  // ----------------------------------------
  logic [5:0] lvl;
  logic [5:0] rise;
  logic [5:0] fall;
  sfr_pin_sync u_sync (
    .clock_in  (clock_in),
    .rst_b_in  (rst_b_in),
    .pins_in   ({bidir_line_in, serial_clock_in, chip_select_b_in}),
    .level_out (lvl),
    .rise_out  (rise),
    .fall_out  (fall)
  );
  wire       cs_high = lvl[0];
  wire       cs_fall = fall[0];
  wire       cs_rise = rise[0];
  wire       sck_up  = rise[1] && !cs_high;
  wire       sck_dn  = fall[1] && !cs_high;
  wire [3:0] din     = lvl[5:2];
  // ----------------------------------------
  // state
  // ----------------------------------------
  sfr_pkg::sfr_state_t        state_ff;
  logic [7:0]                 op_ff;
  logic [5:0]                 cnt_ff;
  logic [5:0]                 dummy_ff;
  logic [3:0]                 alanes_ff;
  logic [3:0]                 dlanes_ff;
  logic                       use32_ff;
  logic [31:0]                addr_ff;
  logic [7:0]                 sh_ff;
  logic [2:0]                 grp_ff;
  logic [7:0]                 col_ff;
  logic                       have_byte_ff;
  logic [7:0]                 page_buf [sfr_pkg::PAGE_BYTES];
  logic [sfr_pkg::PAGE_BYTES-1:0] mask_ff;
  logic                       busy_ff;
  logic [sfr_pkg::BUSY_W-1:0] busy_cnt_ff;
  logic                       wel_ff;
  logic [3:0]                 io_ff;
  logic [3:0]                 oe_ff;
  logic                       we_ff;
  logic [31:0]                paddr_ff;
  logic [7:0]                 pdata_ff;
  // ----------------------------------------
  // opcode decode
  // ----------------------------------------
  wire [7:0] op_w     = {op_ff[6:0], din[0]};
  wire is_fast  = (op_w == sfr_pkg::OP_FAST_RD)  || (op_w == sfr_pkg::OP_FAST_RD4);
  wire is_dout  = (op_w == sfr_pkg::OP_DUAL_OUT) || (op_w == sfr_pkg::OP_DUAL_OUT4);
  wire is_qout  = (op_w == sfr_pkg::OP_QUAD_OUT) || (op_w == sfr_pkg::OP_QUAD_OUT4);
  wire is_dio   = (op_w == sfr_pkg::OP_DUAL_IO)  || (op_w == sfr_pkg::OP_DUAL_IO4);
  wire is_qio   = (op_w == sfr_pkg::OP_QUAD_IO)  || (op_w == sfr_pkg::OP_QUAD_IO4);
  wire is_read  = is_fast || is_dout || is_qout || is_dio || is_qio;
  wire is_prog  = (op_w == sfr_pkg::OP_PAGE_PROG);
  wire force32  = (op_w == sfr_pkg::OP_FAST_RD4) || (op_w == sfr_pkg::OP_DUAL_OUT4)
               || (op_w == sfr_pkg::OP_QUAD_OUT4);
  wire force32b = (op_w == sfr_pkg::OP_DUAL_IO4) || (op_w == sfr_pkg::OP_QUAD_IO4);
  wire use32_w  = force32 || force32b || address_size_select_in;
  wire [3:0] alanes_w = is_qio ? sfr_pkg::LINES_4 : (is_dio ? sfr_pkg::LINES_2
                                                            : sfr_pkg::LINES_1);
  wire [3:0] dlanes_w = (is_qio || is_qout) ? sfr_pkg::LINES_4
                      : ((is_dio || is_dout) ? sfr_pkg::LINES_2 : sfr_pkg::LINES_1);
  wire [5:0] dummy_w  = is_qio ? sfr_pkg::DUMMY_QUAD_IO
                      : (is_dio ? sfr_pkg::DUMMY_DUAL_IO : sfr_pkg::DUMMY_FAST);
  wire [5:0] abits_w  = use32_w ? 6'h20 : 6'h18;
  wire [5:0] aclk_w   = (alanes_w == sfr_pkg::LINES_4) ? {2'b00, abits_w[5:2]}
                      : ((alanes_w == sfr_pkg::LINES_2) ? {1'b0, abits_w[5:1]} : abits_w);
  wire read_ok  = is_read && !busy_ff;
  wire prog_ok  = is_prog && wel_ff && !busy_ff;
  // ----------------------------------------
  // address and data paths
  // ----------------------------------------
  wire [31:0] addr_sh = (alanes_ff == sfr_pkg::LINES_4) ? {addr_ff[27:0], din}
                      : ((alanes_ff == sfr_pkg::LINES_2) ? {addr_ff[29:0], din[1:0]}
                                                         : {addr_ff[30:0], din[0]});
  wire [31:0] addr_fin = use32_ff ? addr_sh : {ext_addr_in, addr_sh[23:0]};
  wire [7:0]  out_byte = (grp_ff == 3'h0) ? mem_rdata_in : sh_ff;
  wire [3:0]  grp_bits = (dlanes_ff == sfr_pkg::LINES_4) ? out_byte[7:4]
                       : ((dlanes_ff == sfr_pkg::LINES_2) ? {2'b00, out_byte[7:6]}
                                                          : {2'b00, out_byte[7], 1'b0});
  wire [3:0]  oe_w     = (dlanes_ff == sfr_pkg::LINES_4) ? sfr_pkg::OE_QUAD
                       : ((dlanes_ff == sfr_pkg::LINES_2) ? sfr_pkg::OE_DUAL
                                                          : sfr_pkg::OE_SINGLE);
  wire [7:0]  sh_next  = out_byte << dlanes_ff;
  wire [2:0]  grp_max  = (dlanes_ff == sfr_pkg::LINES_4) ? 3'h1
                       : ((dlanes_ff == sfr_pkg::LINES_2) ? 3'h3 : 3'h7);
  wire        byte_end = sck_up && (state_ff == sfr_pkg::ST_PDATA) && (cnt_ff == 6'h00);
  wire [7:0]  byte_w   = {sh_ff[6:0], din[0]};
  wire        commit   = cs_rise && (state_ff == sfr_pkg::ST_PDATA)
                      && (cnt_ff == sfr_pkg::BIT_LAST) && have_byte_ff;
  wire        start_pp = commit && !page_locked_in;
  wire        walk     = busy_ff && (busy_cnt_ff < sfr_pkg::BUSY_W'(sfr_pkg::PAGE_BYTES));
  wire [7:0]  widx     = busy_cnt_ff[7:0];
  wire        done     = busy_ff && (busy_cnt_ff == PROG_LAST);
  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_b_in || cs_high) begin
      state_ff <= sfr_pkg::ST_IDLE;
      oe_ff    <= 4'h0;
      io_ff    <= 4'h0;
      if (!rst_b_in) begin
        op_ff <= 8'h00; cnt_ff <= 6'h00; dummy_ff <= 6'h00; alanes_ff <= sfr_pkg::LINES_1;
        dlanes_ff <= sfr_pkg::LINES_1; use32_ff <= 1'b0; addr_ff <= 32'h0000_0000;
        sh_ff <= 8'h00; grp_ff <= 3'h0; col_ff <= 8'h00; have_byte_ff <= 1'b0;
      end
    end else if (cs_fall) begin
      state_ff <= sfr_pkg::ST_OPC;
      cnt_ff   <= sfr_pkg::BIT_LAST;
    end else if (sck_up) begin
      unique case (state_ff)
        sfr_pkg::ST_OPC: begin
          op_ff  <= op_w;
          cnt_ff <= cnt_ff - 6'h01;
          if (cnt_ff == 6'h00) begin
            state_ff  <= (read_ok || prog_ok) ? sfr_pkg::ST_ADDR : sfr_pkg::ST_SKIP;
            cnt_ff    <= aclk_w - 6'h01;
            alanes_ff <= alanes_w;
            dlanes_ff <= dlanes_w;
            dummy_ff  <= dummy_w;
            use32_ff  <= use32_w;
            have_byte_ff <= 1'b0;
          end
        end
        sfr_pkg::ST_ADDR: begin
          addr_ff <= addr_sh;
          cnt_ff  <= cnt_ff - 6'h01;
          if (cnt_ff == 6'h00) begin
            addr_ff  <= addr_fin;
            col_ff   <= addr_fin[7:0];
            grp_ff   <= 3'h0;
            state_ff <= (op_ff == sfr_pkg::OP_PAGE_PROG) ? sfr_pkg::ST_PDATA
                                                         : sfr_pkg::ST_DUMMY;
            cnt_ff   <= (op_ff == sfr_pkg::OP_PAGE_PROG) ? sfr_pkg::BIT_LAST
                                                         : dummy_ff - 6'h01;
          end
        end
        sfr_pkg::ST_DUMMY: begin
          cnt_ff <= cnt_ff - 6'h01;
          if (cnt_ff == 6'h00) begin
            state_ff <= sfr_pkg::ST_RDATA;
          end
        end
        sfr_pkg::ST_PDATA: begin
          sh_ff  <= byte_w;
          cnt_ff <= (cnt_ff == 6'h00) ? sfr_pkg::BIT_LAST : cnt_ff - 6'h01;
          if (cnt_ff == 6'h00) begin
            col_ff       <= col_ff + 8'h01;
            have_byte_ff <= 1'b1;
          end
        end
        sfr_pkg::ST_IDLE, sfr_pkg::ST_RDATA, sfr_pkg::ST_SKIP: begin
        end
      endcase
    end else if (sck_dn && (state_ff == sfr_pkg::ST_RDATA)) begin
      // host must have released the lines by this edge
      io_ff  <= grp_bits;
      oe_ff  <= oe_w;
      sh_ff  <= sh_next;
      grp_ff <= (grp_ff == 3'h0) ? grp_max : grp_ff - 3'h1;
      if (grp_ff == 3'h0) begin
        addr_ff <= addr_ff + 32'h0000_0001;
      end
    end
  end
  // ----------------------------------------
  // page buffer; unsent bytes keep their mask clear and are never written
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (byte_end) begin
      page_buf[col_ff] <= byte_w;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < sfr_pkg::PAGE_BYTES; gi++) begin : g_mask
      always_ff @(posedge clock_in) begin
        if (!rst_b_in || (sck_up && (state_ff == sfr_pkg::ST_OPC) && (cnt_ff == 6'h00)
                          && prog_ok)) begin
          mask_ff[gi] <= 1'b0;
        end else if (byte_end && (col_ff == 8'(gi))) begin
          mask_ff[gi] <= 1'b1;
        end
      end
    end
  endgenerate
  // ----------------------------------------
  // self-timed program cycle; this die alone owns its busy flag
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      busy_ff <= 1'b0; busy_cnt_ff <= '0; wel_ff <= 1'b0;
      we_ff <= 1'b0; paddr_ff <= 32'h0000_0000; pdata_ff <= 8'h00;
    end else begin
      we_ff <= walk && mask_ff[widx];
      paddr_ff <= {addr_ff[31:8], widx};
      pdata_ff <= page_buf[widx];
      if (start_pp && !busy_ff) begin
        busy_ff     <= 1'b1;
        busy_cnt_ff <= '0;
      end else if (done) begin
        busy_ff <= 1'b0;
      end else if (busy_ff) begin
        busy_cnt_ff <= busy_cnt_ff + sfr_pkg::BUSY_W'(1);
      end
      // a set arriving with the clear wins
      if (write_enable_set_in) begin
        wel_ff <= 1'b1;
      end else if (done) begin
        wel_ff <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign bidir_line_out         = io_ff;
  assign bidir_line_oe_out      = oe_ff;
  assign write_enable_latch_out = wel_ff;
  assign busy_out               = busy_ff;
  assign mem_addr_out           = addr_ff;
  assign prog_we_out            = we_ff;
  assign prog_addr_out          = paddr_ff;
  assign prog_data_out          = pdata_ff;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  a_busy_needs_wel:  assert property ($rose(busy_ff) |-> wel_ff)
    else $error("busy started without write enable");
  a_done_clears_wel: assert property (done && !write_enable_set_in |=> !wel_ff && !busy_ff)
    else $error("write enable not cleared at end");
  a_read_not_busy:   assert property (state_ff == sfr_pkg::ST_RDATA |-> !busy_ff)
    else $error("read ran during busy");
  a_dummy_undriven:  assert property (state_ff == sfr_pkg::ST_DUMMY |-> oe_ff == 4'h0)
    else $error("lines driven in dummy clocks");
  a_quad_lanes_oe:   assert property (oe_ff == sfr_pkg::OE_QUAD
                                      |-> dlanes_ff == sfr_pkg::LINES_4)
    else $error("quad drive on non-quad read");
  a_dual_lanes_oe:   assert property (oe_ff == sfr_pkg::OE_DUAL
                                      |-> dlanes_ff == sfr_pkg::LINES_2)
    else $error("dual drive on non-dual read");
  a_boundary_only:   assert property ($rose(busy_ff) |-> $past(cnt_ff) == sfr_pkg::BIT_LAST)
    else $error("program started off a byte boundary");
  a_locked_skip:     assert property (commit && page_locked_in && !busy_ff |=> !busy_ff)
    else $error("locked page programmed");
  a_wrap_page:       assert property (byte_end && col_ff == 8'hFF |=> col_ff == 8'h00)
    else $error("column did not wrap");
  a_write_in_page:   assert property (we_ff |-> paddr_ff[31:8] == addr_ff[31:8])
    else $error("program write left the page");
  a_release_oe:      assert property (cs_high |=> oe_ff == 4'h0)
    else $error("lines driven with select high");
  c_prog_cycle: cover property ($rose(busy_ff));
  c_quad_read:  cover property (oe_ff == sfr_pkg::OE_QUAD);
  c_dual_io:    cover property (state_ff == sfr_pkg::ST_RDATA && alanes_ff == sfr_pkg::LINES_2);
  c_wrap:       cover property (byte_end && col_ff == 8'hFF);
endmodule

// file: sfr_host_model.sv
// host side of the serial link: select, serial clock and four data lines.
// assumes every task is entered just after a system clock rise.
`timescale 1ns/10ps
module sfr_host_model (
  // device side of the pins
  input  wire logic [3:0] dev_line_in,
  input  wire logic [3:0] dev_oe_in,
  // pins as seen on the board
  output logic            chip_select_b_out,
  output logic            serial_clock_out,
  output logic      [3:0] line_out
);
  logic [3:0] host_val;
  logic [3:0] host_oe;
  // a released line shows the inverse of its last value, never a kind guess
  assign line_out = (dev_oe_in & dev_line_in) | (~dev_oe_in & host_oe & host_val)
                  | (~dev_oe_in & ~host_oe & ~host_val);
  initial begin
    chip_select_b_out = 1'b1;
    serial_clock_out = 1'b0;
    host_val = 4'h0;
    host_oe = 4'h0;
  end
  // clock stands low between frames; drive after fall, sample late in the high phase
  task automatic tick(output logic [3:0] smp);
    #160 serial_clock_out = 1'b1;
    #150 smp = line_out;
    #10 serial_clock_out = 1'b0;
  endtask
  task automatic open_frame();
    chip_select_b_out = 1'b0;
    #320;
  endtask
  task automatic shift(input int lanes, input int nbits, input logic [31:0] val);
    logic [3:0] s;
    for (int g = 0; g < nbits / lanes; g++) begin
      host_oe = (lanes == 4) ? 4'hF : (lanes == 2) ? 4'h3 : 4'h1;
      for (int l = 0; l < lanes; l++) begin
        host_val[l] = val[nbits - 1 - g * lanes - (lanes - 1 - l)];
      end
      tick(s);
    end
  endtask
  task automatic dummies(input int n);
    logic [3:0] s;
    host_oe = 4'h0;
    repeat (n) tick(s);
  endtask
  task automatic rd(input int lanes, input int nbytes, output logic [15:0] data);
    logic [3:0] s;
    data = 16'h0000;
    for (int i = 0; i < nbytes * 8 / lanes; i++) begin
      tick(s);
      for (int l = lanes - 1; l >= 0; l--) data = {data[14:0], (lanes == 1) ? s[1] : s[l]};
    end
  endtask
  task automatic close_frame();
    host_oe = 4'h0;
    chip_select_b_out = 1'b1;
    #400;
  endtask
endmodule

// file: sfr_read_prog_top_bench.sv
// self-checking bench for the read and page program command logic.
// assumes the host model and a byte array answering from the read address.
`timescale 1ns/10ps
module sfr_read_prog_top_bench;
  logic clock_in, rst_b_in, address_size_select, wes, locked;
  logic [7:0] ext;
  logic [3:0] dout, doe, lines, oe_seen;
  logic cs_b, sclk, write_enable_latch, busy, pwe;
  logic [31:0] maddr, paddr;
  logic [7:0] pdata, wr [0:255];
  logic [23:0] page;
  int err_total, checked, wr_n, cyc;
  sfr_read_prog_top #(.PROG_TIME_NS(12000)) u_dut (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .chip_select_b_in(cs_b),
    .serial_clock_in(sclk), .bidir_line_in(lines), .bidir_line_out(dout),
    .bidir_line_oe_out(doe), .address_size_select_in(address_size_select), .ext_addr_in(ext),
    .write_enable_set_in(wes), .page_locked_in(locked), .write_enable_latch_out(write_enable_latch),
    .busy_out(busy), .mem_addr_out(maddr), .mem_rdata_in(mem_byte(maddr)),
    .prog_we_out(pwe), .prog_addr_out(paddr), .prog_data_out(pdata));
  sfr_host_model u_host (.dev_line_in(dout), .dev_oe_in(doe), .chip_select_b_out(cs_b),
    .serial_clock_out(sclk), .line_out(lines));
  function automatic logic [7:0] mem_byte(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ a[31:24] ^ 8'h3C;
  endfunction
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cyc++;
    oe_seen = oe_seen | doe;
    if (pwe === 1'b1) begin
      wr[paddr[7:0]] = pdata;
      page = paddr[31:8];
      wr_n++;
    end
    if (cyc == 60000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      err_total++;
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic pulse_wel();
    @(posedge clock_in) #1 wes = 1'b1;
    @(posedge clock_in) #1 wes = 1'b0;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(posedge clock_in);
    #1;
  endtask
  task automatic do_read(input logic [7:0] op, input int al, input int dl, input int dum,
                         input int nb, input logic [31:0] a, output logic [15:0] d);
    @(posedge clock_in) #1 u_host.open_frame();
    u_host.shift(1, 8, {24'h0, op});
    u_host.shift(al, (a[31:24] != 8'h00) ? 32 : 24, a);
    u_host.dummies(dum);
    u_host.rd(dl, nb, d);
    u_host.close_frame();
  endtask
  task automatic do_prog(input logic [31:0] a, input int n, input int extra);
    @(posedge clock_in) #1 u_host.open_frame();
    u_host.shift(1, 8, 32'h02);
    u_host.shift(1, 24, a);
    for (int i = 0; i < n; i++) u_host.shift(1, 8, (i >= 256) ? 32'hC3 : i[7:0]);
    if (extra > 0) u_host.shift(1, extra, 32'h5);
    u_host.close_frame();
  endtask
  task automatic t_reads();
    logic [15:0] d;
    logic [31:0] a, full;
    logic [7:0] ops [0:10];
    int al, dl;
    // one opcode per scenario: every fast read family member, then 0B again in 4-byte mode
    ops = '{sfr_pkg::OP_FAST_RD, sfr_pkg::OP_FAST_RD4, sfr_pkg::OP_DUAL_OUT,
            sfr_pkg::OP_DUAL_OUT4, sfr_pkg::OP_QUAD_OUT, sfr_pkg::OP_QUAD_OUT4,
            sfr_pkg::OP_DUAL_IO, sfr_pkg::OP_DUAL_IO4, sfr_pkg::OP_QUAD_IO,
            sfr_pkg::OP_QUAD_IO4, sfr_pkg::OP_FAST_RD};
    for (int k = 0; k < 11; k++) begin
      al = (k < 6 || k == 10) ? 1 : (k < 8) ? 2 : 4;
      dl = (k < 2 || k == 10) ? 1 : (k < 4 || k == 6 || k == 7) ? 2 : 4;
      address_size_select = (k == 10);
      a = (k[0] || k == 10) ? 32'h7E1234FF : 32'h001234FF;
      full = a[31:24] != 8'h00 ? a : {ext, a[23:0]};
      do_read(ops[k], al, dl,
              (k < 6 || k == 10) ? 8 : (k < 8) ? 4 : 6, 2, a, d);
      check("read bytes", d, {mem_byte(full), mem_byte(full + 1)});
    end
    address_size_select = 1'b0;
  endtask
  task automatic t_prog(input int n, input logic [7:0] last, input int cnt);
    wr_n = 0;
    pulse_wel();
    do_prog(32'h0012FE, n, 0);
    check("busy during cycle", {busy, write_enable_latch}, 2'b11);
    wait_idle();
    check("wel after cycle", {busy, write_enable_latch}, 2'b00);
    check("columns written", wr_n, cnt);
    check("page", page, {ext, 16'h0012});
    check("wrapped byte", wr[8'hFF], last);
    check("first column", wr[8'h00], 8'h02);
  endtask
  task automatic t_refused();
    do_prog(32'h000100, 1, 0);
    check("no wel", busy, 1'b0);
    pulse_wel();
    do_prog(32'h000100, 1, 4);
    check("ragged select", {busy, write_enable_latch}, 2'b01);
    locked = 1'b1;
    do_prog(32'h000100, 1, 0);
    check("locked page", {busy, write_enable_latch}, 2'b01);
    locked = 1'b0;
  endtask
  task automatic t_read_busy();
    logic [15:0] d;
    do_prog(32'h000200, 1, 0);
    oe_seen = 4'h0;
    do_read(8'hEB, 4, 4, 6, 1, 32'h000200, d);
    check("read while busy", {busy, oe_seen}, 5'h10);
    wait_idle();
  endtask
  initial begin
    {rst_b_in, address_size_select, wes, locked, err_total, checked, wr_n, cyc} = '0;
    ext = 8'hA5;
    oe_seen = 4'h0;
    repeat (2) @(posedge clock_in);
    #1 rst_b_in = 1'b1;
    repeat (6) @(posedge clock_in);
    #1 check("reset state", {busy, write_enable_latch, doe}, 6'h00);
    t_reads();
    t_prog(3, 8'h01, 3);
    t_prog(258, 8'hC3, 256);
    t_refused();
    t_read_busy();
    stop_test();
  end
endmodule
